// ==== verilog/capture_pkg.sv ====
package capture_pkg;
    // ------------------------------------------------------------
    // mode field encodings
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_ANY_EDGE = 4'h3;
    localparam logic [3:0] MODE_FALL = 4'h4;
    localparam logic [3:0] MODE_RISE = 4'h5;
    localparam logic [3:0] MODE_RISE4 = 4'h6;
    localparam logic [3:0] MODE_RISE16 = 4'h7;
    // ------------------------------------------------------------
    // widths, counts, reset values
    // ------------------------------------------------------------
    localparam int COUNT_W = 16;
    localparam int BYTE_W = 8;
    localparam int NUM_TIMERS = 3;
    localparam int NUM_SOURCES = 4;
    localparam logic [3:0] PRESCALE_4 = 4'h3;
    localparam logic [3:0] PRESCALE_16 = 4'hf;
    localparam logic [1:0] TIMER_SEL_RESET = 2'h0;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
endpackage : capture_pkg

// ==== verilog/timer_capture_unit.sv ====
// Summary of operation
// RULE1: each qualifying event copies the selected 16-bit timer count into the capture register.
// RULE2: mode picks falling, rising, every 4th rising, every 16th rising, or any edge.
// RULE3: every capture sets the flag; only software clears it.
// RULE4: a new capture overwrites an unread held value.
// RULE5: software disables the unit or reads bytes twice to avoid mixed events.
// RULE6: a source-select field picks the signal feeding the capture input.
// RULE7: with the pin as output, a port latch write can cause a capture.
// RULE8: capture uses the first, third or fifth timer; the first by default.
// RULE9: several units may share one timer in the same mode family.
// RULE10: the timer runs in timer or synchronized counter mode.
// RULE11: the timer is clocked from instruction clock or external, not system clock.
// RULE12: mode changes may set a false flag; software masks and clears it.
// RULE13: prescaler counter clears when off, not in capture mode, or reset.
// RULE14: switching prescaler settings directly keeps the counter; may give false capture.
// RULE15: the capture value reads as separate low and high bytes.
// RULE16: in output modes the pin driver may be open-drain.
// RULE17: captures continue in sleep with an externally clocked timer.
// RULE18: the capture input is synchronised and edges found from registered samples.
// RULE19: divided modes restart the prescaler after each capture.
module timer_capture_unit
    import capture_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic unit_enable,
    input wire logic [3:0] mode,
    input wire logic [1:0] source_select,
    input wire logic [1:0] timer_select,
    input wire logic [COUNT_W-1:0] timebase_count_1,
    input wire logic [COUNT_W-1:0] timebase_count_3,
    input wire logic [COUNT_W-1:0] timebase_count_5,
    input wire logic capture_pin_in,
    input wire logic pin_direction_control,
    input wire logic port_latch,
    input wire logic [NUM_SOURCES-2:0] internal_sources,
    input wire logic open_drain_enable,
    input wire logic output_level,
    input wire logic flag_clear,
    output logic capture_event_flag,
    output logic capture_pulse,
    output logic [BYTE_W-1:0] capture_value_low_byte,
    output logic [BYTE_W-1:0] capture_value_high_byte,
    output logic pin_out,
    output logic pin_oe_n
);
    // ------------------------------------------------------------
    // source selection
    // ------------------------------------------------------------
    logic pin_level;
    logic raw_source;
    logic sync_first;
    logic sync_second;
    logic sample_prev;
    logic capture_mode;
    logic rise;
    logic fall;
    logic edge_hit;
    logic [3:0] prescale;
    logic [3:0] prescale_limit;
    logic prescaled_mode;
    logic take;
    logic [COUNT_W-1:0] selected_count;
    logic [COUNT_W-1:0] capture_value_register;

    // output pin reads back the port latch
    assign pin_level = pin_direction_control ? capture_pin_in : port_latch; // RULE7

    always_comb begin
        unique case (source_select) // RULE6
            2'h0: raw_source = pin_level;
            2'h1: raw_source = internal_sources[0];
            2'h2: raw_source = internal_sources[1];
            default: raw_source = internal_sources[2];
        endcase
    end

    // ------------------------------------------------------------
    // synchroniser and edge detect
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_first <= 1'b0;
            sync_second <= 1'b0;
            sample_prev <= 1'b0;
        end else begin
            sync_first <= raw_source; // RULE18
            sync_second <= sync_first;
            sample_prev <= sync_second;
        end
    end

    assign rise = sync_second && !sample_prev; // RULE18
    assign fall = !sync_second && sample_prev;
    assign capture_mode = unit_enable && (mode == MODE_ANY_EDGE || mode == MODE_FALL || mode == MODE_RISE
                                          || mode == MODE_RISE4 || mode == MODE_RISE16);
    assign prescaled_mode = (mode == MODE_RISE4) || (mode == MODE_RISE16);
    assign prescale_limit = (mode == MODE_RISE16) ? PRESCALE_16 : PRESCALE_4;

    always_comb begin
        unique case (mode) // RULE2
            MODE_ANY_EDGE: edge_hit = rise || fall;
            MODE_FALL: edge_hit = fall;
            MODE_RISE: edge_hit = rise;
            MODE_RISE4: edge_hit = rise;
            MODE_RISE16: edge_hit = rise;
            default: edge_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------
    assign take = capture_mode && edge_hit && (!prescaled_mode || prescale >= prescale_limit); // RULE2

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale <= 4'h0; // RULE13
        end else if (!capture_mode) begin
            prescale <= 4'h0; // RULE13
        end else if (prescaled_mode && rise) begin
            // a direct prescaler switch keeps the count running
            if (take) begin
                prescale <= 4'h0; // RULE19
            end else begin
                prescale <= prescale + 4'h1; // RULE14
            end
        end
    end

    // ------------------------------------------------------------
    // timer choice and capture register
    // ------------------------------------------------------------
    always_comb begin
        unique case (timer_select) // RULE8
            2'h1: selected_count = timebase_count_3;
            2'h2: selected_count = timebase_count_5;
            default: selected_count = timebase_count_1;
        endcase
    end

    // timers are read only, so several units may share one
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_value_register <= CAPTURE_RESET;
        end else if (take) begin
            capture_value_register <= selected_count; // RULE1 RULE4 RULE9 RULE17
        end
    end

    assign capture_value_low_byte = capture_value_register[BYTE_W-1:0]; // RULE15
    assign capture_value_high_byte = capture_value_register[COUNT_W-1:BYTE_W]; // RULE15 RULE5

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_event_flag <= 1'b0;
        end else if (take) begin
            capture_event_flag <= 1'b1; // RULE3 RULE12
        end else if (flag_clear) begin
            capture_event_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            capture_pulse <= 1'b0;
        end else begin
            capture_pulse <= take;
        end
    end

    // ------------------------------------------------------------
    // pin driver, open drain option in output modes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end else if (!unit_enable || capture_mode || pin_direction_control) begin
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end else if (open_drain_enable) begin
            pin_out <= 1'b0; // RULE16
            pin_oe_n <= output_level;
        end else begin
            pin_out <= output_level;
            pin_oe_n <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // assertion helpers
    // ------------------------------------------------------------
    logic [1:0] settle;

    // source history only matches the sync stages three edges after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // assertions: capture register and flag
    // ------------------------------------------------------------
    a_capture_loads_count: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
        take |=> capture_value_register == $past(selected_count))
        else $error("capture value not loaded");
    a_timer1_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        take && timer_select inside {2'h0, 2'h3}
        |=> capture_value_register == $past(timebase_count_1))
        else $error("first timer not captured");
    a_timer3_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        take && timer_select == 2'h1
        |=> capture_value_register == $past(timebase_count_3))
        else $error("third timer not captured");
    a_timer5_capture: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
        take && timer_select == 2'h2
        |=> capture_value_register == $past(timebase_count_5))
        else $error("fifth timer not captured");
    a_bytes_split: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
        take |=> {capture_value_high_byte, capture_value_low_byte} == $past(selected_count))
        else $error("byte split wrong");
    a_value_holds_idle: assert property (@(posedge clk) disable iff (!rst_n) // RULE4
        !take |=> $stable(capture_value_register))
        else $error("capture value changed without event");
    a_flag_sets_on_take: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        take |=> capture_event_flag && capture_pulse)
        else $error("flag not set on capture");
    a_flag_sticky_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        capture_event_flag && !flag_clear |=> capture_event_flag)
        else $error("flag dropped without clear");
    a_flag_clear_works: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        flag_clear && !take |=> !capture_event_flag)
        else $error("flag not cleared");
    a_pulse_one_cycle: assert property (@(posedge clk) disable iff (!rst_n) // RULE3
        capture_pulse && !take |=> !capture_pulse)
        else $error("capture pulse too long");

    // ------------------------------------------------------------
    // assertions: source and edge qualification
    // ------------------------------------------------------------
    a_source_map: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
        source_select != 2'h0 |-> raw_source == internal_sources[source_select - 2'h1])
        else $error("wrong internal source");
    a_latch_path: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
        source_select == 2'h0 && !pin_direction_control |-> raw_source == port_latch)
        else $error("port latch not on capture path");
    a_sync_latency: assert property (@(posedge clk) disable iff (!rst_n) // RULE18
        settle == 2'h3 && rise |-> $past(raw_source, 2) && !$past(raw_source, 3))
        else $error("edge not from synchronised samples");
    a_fall_mode_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        settle == 2'h3 && take && mode == MODE_FALL |-> !$past(raw_source, 2) && $past(raw_source, 3))
        else $error("fall capture without falling edge");
    a_rise_mode_only: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        settle == 2'h3 && take && mode == MODE_RISE |-> $past(raw_source, 2) && !$past(raw_source, 3))
        else $error("rise capture without rising edge");
    a_any_edge_both: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        settle == 2'h3 && unit_enable && mode == MODE_ANY_EDGE
        && $past(raw_source, 2) != $past(raw_source, 3) |-> take)
        else $error("edge missed in any edge mode");
    a_fall_ignores_rise: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        mode == MODE_FALL && rise |-> !take)
        else $error("rise captured in fall mode");
    a_rise_ignores_fall: assert property (@(posedge clk) disable iff (!rst_n) // RULE2
        (mode == MODE_RISE || prescaled_mode) && fall |-> !take)
        else $error("fall captured in rise mode");

    // ------------------------------------------------------------
    // assertions: prescaler
    // ------------------------------------------------------------
    a_prescaler_cleared_off: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        !capture_mode |=> prescale == 4'h0)
        else $error("prescaler not cleared");
    a_prescaler_restarts: assert property (@(posedge clk) disable iff (!rst_n) // RULE19
        take && prescaled_mode |=> prescale == 4'h0)
        else $error("prescaler not restarted");
    a_prescale_counts: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        capture_mode && prescaled_mode && rise && !take |=> prescale == $past(prescale) + 4'h1)
        else $error("prescaler missed a rise");
    a_prescale_holds: assert property (@(posedge clk) disable iff (!rst_n) // RULE14
        capture_mode && !(prescaled_mode && rise) |=> $stable(prescale))
        else $error("prescaler changed without a rise");
    a_disabled_quiet: assert property (@(posedge clk) disable iff (!rst_n) // RULE13
        !capture_mode |=> !capture_pulse && $stable(capture_value_register))
        else $error("capture while not in capture mode");

    // ------------------------------------------------------------
    // assertions: pin driver
    // ------------------------------------------------------------
    a_open_drain_drive: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
        !pin_oe_n && $past(open_drain_enable) |-> !pin_out)
        else $error("open drain drove high");
    a_push_pull_level: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
        !pin_oe_n && !$past(open_drain_enable) |-> pin_out == $past(output_level))
        else $error("push pull level wrong");
    a_pin_released: assert property (@(posedge clk) disable iff (!rst_n) // RULE16
        !unit_enable || capture_mode || pin_direction_control |=> pin_oe_n && !pin_out)
        else $error("pin driven outside output mode");

    // ------------------------------------------------------------
    // cover properties
    // ------------------------------------------------------------
    c_rise16_capture: cover property (@(posedge clk) disable iff (!rst_n) take && mode == MODE_RISE16);
    c_any_edge_capture: cover property (@(posedge clk) disable iff (!rst_n) take && mode == MODE_ANY_EDGE);
    c_set_beats_clear: cover property (@(posedge clk) disable iff (!rst_n) take && flag_clear);
    c_latch_capture: cover property (@(posedge clk) disable iff (!rst_n) take && !pin_direction_control);
    c_prescale_switch: cover property (@(posedge clk) disable iff (!rst_n)
        prescaled_mode && $changed(mode) && prescale != 4'h0);
endmodule : timer_capture_unit

// ==== bench/signal_source.sv ====
// ------------------------------------------------------------
// external signal source on the capture pin
// ------------------------------------------------------------
module signal_source (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic want,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic held;
    // want is taken on the rising edge, where it is settled, so no race with the bench
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held <= 1'b0;
        end else begin
            held <= want;
        end
    end
    // level changes only on falling edges and is held between them
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin <= 1'b0;
        end else begin
            pin <= held;
        end
    end
endmodule : signal_source

// ==== bench/timer_capture_unit_test.sv ====
module timer_capture_unit_test
    import capture_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0, rst_n = 1'b0, unit_enable = 1'b0, flag_clear = 1'b0, want = 1'b0, pin;
    logic pin_direction_control = 1'b1, port_latch = 1'b0, open_drain_enable = 1'b0, output_level = 1'b0;
    logic [3:0] mode = MODE_OFF;
    logic [1:0] source_select = 2'h0, timer_select = 2'h0;
    logic [15:0] timebase_count_1 = 16'h0000, timebase_count_3 = 16'h0000, timebase_count_5 = 16'h0000;
    logic [2:0] internal_sources = 3'h0;
    logic capture_event_flag, capture_pulse, pin_out, pin_oe_n;
    logic [7:0] capture_value_low_byte, capture_value_high_byte;
    logic [15:0] last = CAPTURE_RESET;
    int err_count = 0, check_count = 0, pulse_count = 0, k;
    localparam logic [3:0] MODES [5] = '{MODE_FALL, MODE_RISE, MODE_ANY_EDGE, MODE_RISE4, MODE_RISE16};
    timer_capture_unit timer_capture_unit_i (.clk(clk), .rst_n(rst_n), .unit_enable(unit_enable), .mode(mode),
        .source_select(source_select), .timer_select(timer_select), .timebase_count_1(timebase_count_1),
        .timebase_count_3(timebase_count_3), .timebase_count_5(timebase_count_5), .capture_pin_in(pin),
        .pin_direction_control(pin_direction_control), .port_latch(port_latch), .internal_sources(internal_sources),
        .open_drain_enable(open_drain_enable), .output_level(output_level), .flag_clear(flag_clear),
        .capture_event_flag(capture_event_flag), .capture_pulse(capture_pulse),
        .capture_value_low_byte(capture_value_low_byte), .capture_value_high_byte(capture_value_high_byte),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n));
    signal_source signal_source_i (.clk(clk), .rst_n(rst_n), .want(want), .pin(pin));
    initial begin
        forever #4 clk = ~clk;
    end
    always @(negedge clk) begin
        if (capture_pulse === 1'b1) pulse_count++;
    end
    // ------------------------------------------------------------
    // compare tasks and expectation functions
    // ------------------------------------------------------------
    task automatic check1(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: flag or pin got %b expected %b", $time, got, exp);
        end
    endtask : check1
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: value byte got %h expected %h", $time, got, exp);
        end
    endtask : check8
    task automatic check_count_of(input int got, input int exp);
        check_count++;
        if (got != exp) begin
            err_count++;
            $display("mismatch at %0t: captures got %0d expected %0d", $time, got, exp);
        end
    endtask : check_count_of
    function automatic logic is_cap(input logic [3:0] m, input logic rise, input int i);
        case (m)
            MODE_RISE: return rise;
            MODE_FALL: return !rise;
            MODE_ANY_EDGE: return 1'b1;
            MODE_RISE4: return rise && (i % 4 == 3);
            MODE_RISE16: return rise && (i % 16 == 15);
            default: return 1'b0;
        endcase
    endfunction : is_cap
    function automatic logic [15:0] pick(input logic [1:0] tsel);
        return (tsel == 2'h1) ? timebase_count_3 : (tsel == 2'h2) ? timebase_count_5 : timebase_count_1;
    endfunction : pick
    // fresh timer counts each edge so a stale sample shows up
    task automatic drive(input logic lvl);
        @(negedge clk);
        timebase_count_1 = 16'($urandom);
        timebase_count_3 = 16'($urandom);
        timebase_count_5 = 16'($urandom);
        if (source_select != 2'h0) internal_sources[source_select - 2'h1] = lvl;
        else if (pin_direction_control) want = lvl;
        else port_latch = lvl;
        repeat (5) @(negedge clk);
    endtask : drive
    task automatic run(input logic [3:0] m, input logic [1:0] tsel, input logic [1:0] src, input logic dir,
                       input int rises);
        int caps;
        caps = 0;
        @(negedge clk);
        unit_enable = 1'b0;
        flag_clear = 1'b1;
        mode = m;
        timer_select = tsel;
        source_select = src;
        pin_direction_control = dir;
        @(negedge clk);
        flag_clear = 1'b0;
        check1(capture_event_flag, 1'b0);
        unit_enable = 1'b1;
        pulse_count = 0;
        for (int i = 0; i < rises; i++) begin
            drive(1'b1);
            if (is_cap(m, 1'b1, i)) begin caps++; last = pick(tsel); end
            drive(1'b0);
            if (is_cap(m, 1'b0, i)) begin caps++; last = pick(tsel); end
        end
        check_count_of(pulse_count, caps);
        check8(capture_value_low_byte, last[7:0]);
        check8(capture_value_high_byte, last[15:8]);
        check1(capture_event_flag, caps > 0);
        $display("test done mode %h timer %0d source %0d captures %0d", m, tsel, src, caps);
    endtask : run
    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : final_report
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(32'hda0b));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        check1(capture_event_flag, 1'b0);
        check8(capture_value_high_byte, CAPTURE_RESET[15:8]);
        run(MODE_RISE, 2'h0, 2'h0, 1'b1, 3);
        run(MODE_FALL, 2'h1, 2'h0, 1'b1, 2);
        run(MODE_ANY_EDGE, 2'h2, 2'h0, 1'b1, 2);
        run(MODE_RISE4, 2'h3, 2'h0, 1'b1, 2);
        run(MODE_RISE4, 2'h0, 2'h0, 1'b1, 8);
        run(MODE_RISE16, 2'h1, 2'h0, 1'b1, 17);
        run(MODE_RISE, 2'h0, 2'h1, 1'b1, 1);
        run(MODE_RISE, 2'h0, 2'h2, 1'b1, 1);
        run(MODE_FALL, 2'h0, 2'h3, 1'b1, 1);
        run(MODE_RISE, 2'h2, 2'h0, 1'b0, 2);
        for (k = 0; k < 4; k++) begin
            run(MODES[$urandom % 5], 2'($urandom % 4), 2'($urandom % 4), 1'b1, 1 + $urandom % 6);
        end
        // clear held only in the capture cycle: the set must win
        run(MODE_RISE, 2'h0, 2'h0, 1'b1, 0);
        @(negedge clk);
        want = 1'b1;
        repeat (3) @(negedge clk);
        flag_clear = 1'b1;
        @(negedge clk);
        flag_clear = 1'b0;
        last = pick(2'h0);
        check1(capture_event_flag, 1'b1);
        check8(capture_value_low_byte, last[7:0]);
        drive(1'b0);
        $display("test done set beats clear");
        // direct prescaler switch keeps the count: first rise captures
        run(MODE_RISE16, 2'h0, 2'h0, 1'b1, 3);
        mode = MODE_RISE4;
        pulse_count = 0;
        drive(1'b1);
        last = pick(2'h0);
        check_count_of(pulse_count, 1);
        check8(capture_value_high_byte, last[15:8]);
        drive(1'b0);
        $display("test done prescaler switch");
        @(negedge clk);
        mode = 4'h2;
        pin_direction_control = 1'b0;
        output_level = 1'b1;
        repeat (3) @(negedge clk);
        check1(pin_oe_n, 1'b0);
        check1(pin_out, 1'b1);
        open_drain_enable = 1'b1;
        output_level = 1'b0;
        repeat (2) @(negedge clk);
        check1(pin_oe_n, 1'b0);
        check1(pin_out, 1'b0);
        output_level = 1'b1;
        repeat (2) @(negedge clk);
        check1(pin_oe_n, 1'b1);
        open_drain_enable = 1'b0;
        mode = MODE_RISE;
        repeat (3) @(negedge clk);
        check1(pin_oe_n, 1'b1);
        $display("test done pin output");
        final_report();
    end
endmodule : timer_capture_unit_test
